// ==== hw/sbps_top.sv ====
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module sbps_top import sbps_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic               core_clk,     // System clock, 25 MHz
  input  wire logic               resetn,       // Async reset, active low
  input  wire logic [7:0]         paddr,        // APB address
  input  wire logic               psel,         // APB select
  input  wire logic               penable,      // APB enable
  input  wire logic               pwrite,       // APB direction
  input  wire logic [31:0]        pwdata,       // APB write data
  output logic [31:0]             prdata,       // APB read data
  output logic                    pready,       // APB ready
  output logic                    pslverr,      // APB error, unmapped address
  input  wire logic               host_cmd,     // Host command arrived, pulse
  input  wire logic               power_off,    // Power shutoff detected
  input  wire logic               inertia_est,  // Inertia estimation active
  input  wire logic [15:0]        norm_p_gain,  // Normal speed P gain
  input  wire logic [15:0]        norm_i_gain,  // Normal speed I gain
  input  wire sbps_sense_t        sense,        // Monitored values
  input  wire sbps_thr_t          thr,          // Alarm thresholds
  input  wire sbps_prog_t         prog,         // Program runner state
  output logic                    servo_on,     // Servo enabled
  output logic                    brake_out,    // 1 = brake released
  output logic                    dyn_brake,    // Dynamic brake active
  output logic [7:0]              alarm_code,   // Active alarm, 0 = none
  output logic [15:0]             speed_p_gain, // Speed loop P gain in use
  output logic [15:0]             speed_i_gain, // Speed loop I gain in use
  output logic signed [15:0]      mon1_out,     // Analog monitor 1
  output logic signed [15:0]      mon2_out      // Analog monitor 2
);

  localparam logic [15:0] PRE_LAST = 16'(MS_CYCLES - 1);

  function automatic logic [15:0] olf_calc(input logic [15:0] cur,
                                           input logic [15:0] det);
    logic [31:0] q;
    q = 32'h0000_0000;
    if (det == 16'h0000) begin
      return 16'hffff;
    end
    q = ({16'h0000, cur} * OLF_SCALE) / {16'h0000, det};
    return (q > 32'h0000_ffff) ? 16'hffff : q[15:0];
  endfunction

  function automatic logic signed [15:0] mon_scale(input logic signed [15:0] x,
                                                   input logic signed [15:0] g);
    logic signed [31:0] p;
    p = 32'(x);
    if (g > 16'sh0000) begin
      p = 32'(x) * 32'(g);
    end else if (g < -16'sh0001) begin
      p = 32'(x) / (-32'(g));
    end
    if (p > 32'sh0000_7fff) begin
      return 16'sh7fff;
    end else if (p < -32'sh0000_8000) begin
      return -16'sh8000;
    end
    return p[15:0];
  endfunction

  function automatic logic [15:0] ms_step(input logic [15:0] c,
                                          input logic tick);
    return (tick && c != 16'hffff) ? c + 16'h0001 : c;
  endfunction

  // Control group state
  sbps_cfg_t   cfg_q, cfg_d;
  sbps_state_t state_q, state_d;
  logic        run_q, run_d;
  logic        tmo_q, tmo_d;
  logic [15:0] pre_q, pre_d;
  logic        tick_q, tick_d;
  logic [15:0] phase_q, phase_d;
  logic [15:0] comm_q, comm_d;
  logic        servo_q, servo_d;
  logic        brake_q, brake_d;
  logic        db_q, db_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;

  // Monitor group state
  logic [15:0]        cmd_olf_q, cmd_olf_d;
  logic [15:0]        act_olf_q, act_olf_d;
  logic [15:0]        temp_q, temp_d;
  logic [15:0]        volt_q, volt_d;
  logic [15:0]        step_q, step_d;
  logic               stop_q, stop_d;
  logic [7:0]         alarm_q, alarm_d;
  logic [15:0]        pg_q, pg_d;
  logic [15:0]        ig_q, ig_d;
  logic signed [15:0] m1_q, m1_d;
  logic signed [15:0] m2_q, m2_d;

  logic        wr_en;
  logic        timeout;
  logic        rel_ok;
  logic [15:0] spd_abs;
  logic [15:0] status;

  assign wr_en   = psel && penable && pwrite;
  // Zero-wait slave; read data was captured in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q;

  assign timeout = run_q && (state_q == ST_ON) && (cfg_q.comm_tmo != 16'h0000) &&
                   (comm_q >= cfg_q.comm_tmo);
  assign rel_ok  = (state_q == ST_ON) && (phase_q >= cfg_q.brk_dly);
  assign spd_abs = sense.speed[15] ? 16'(-sense.speed) : 16'(sense.speed);

  always_comb begin
    status               = 16'h0000;
    status[ST_SERVO_BIT] = servo_q;
    status[ST_BRAKE_BIT] = brake_q;
    status[ST_DB_BIT]    = db_q;
    status[ST_TMO_BIT]   = tmo_q;
    status[ST_STOP_BIT]  = stop_q;
  end

  always_comb begin
    cfg_d   = cfg_q;
    run_d   = run_q;
    tmo_d   = tmo_q;
    state_d = state_q;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    // Millisecond prescaler
    tick_d  = (pre_q == PRE_LAST);
    pre_d   = tick_d ? 16'h0000 : pre_q + 16'h0001;
    // Loss of host traffic behaves like a servo-off command
    if (timeout) begin
      run_d = 1'b0;
      tmo_d = 1'b1;
    end
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          run_d = pwdata[CTRL_RUN_BIT];
          if (pwdata[ST_TMO_BIT] && !timeout) begin
            tmo_d = 1'b0;
          end
        end
        OFS_P_GAIN:    cfg_d.p_gain    = pwdata[15:0];
        OFS_I_GAIN:    cfg_d.i_gain    = pwdata[15:0];
        OFS_BRK_DLY:   cfg_d.brk_dly   = pwdata[15:0];
        OFS_COMM_TMO:  cfg_d.comm_tmo  = pwdata[15:0];
        OFS_BRK_MODE:  cfg_d.brk_mode  = pwdata[15:0];
        OFS_DB_COND:   cfg_d.db_cond   = pwdata[7:0];
        OFS_SOFF_DLY:  cfg_d.soff_dly  = pwdata[15:0];
        OFS_STOP_SPD:  cfg_d.stop_spd  = pwdata[15:0];
        OFS_MON1_GAIN: cfg_d.mon1_gain = pwdata[15:0];
        OFS_MON2_GAIN: cfg_d.mon2_gain = pwdata[15:0];
        default: ;
      endcase
    end
    if (psel && !penable) begin
      rdata_d = 32'h0000_0000;
      case (paddr)
        OFS_CTRL:      rdata_d[CTRL_RUN_BIT] = run_q;
        OFS_P_GAIN:    rdata_d[15:0] = cfg_q.p_gain;
        OFS_I_GAIN:    rdata_d[15:0] = cfg_q.i_gain;
        OFS_BRK_DLY:   rdata_d[15:0] = cfg_q.brk_dly;
        OFS_COMM_TMO:  rdata_d[15:0] = cfg_q.comm_tmo;
        OFS_BRK_MODE:  rdata_d[15:0] = cfg_q.brk_mode;
        OFS_DB_COND:   rdata_d[7:0]  = cfg_q.db_cond;
        OFS_SOFF_DLY:  rdata_d[15:0] = cfg_q.soff_dly;
        OFS_STOP_SPD:  rdata_d[15:0] = cfg_q.stop_spd;
        OFS_MON1_GAIN: rdata_d[15:0] = cfg_q.mon1_gain;
        OFS_MON2_GAIN: rdata_d[15:0] = cfg_q.mon2_gain;
        OFS_CMD_OLF:   rdata_d[15:0] = cmd_olf_q;
        OFS_ACT_OLF:   rdata_d[15:0] = act_olf_q;
        OFS_TEMP:      rdata_d[15:0] = temp_q;
        OFS_VOLT:      rdata_d[15:0] = volt_q;
        OFS_STEP_STAT: rdata_d[15:0] = step_q;
        OFS_STATUS:    rdata_d[15:0] = status;
        OFS_ALARM:     rdata_d[7:0]  = alarm_q;
        default:       err_d = 1'b1;
      endcase
    end
    // Servo sequencing
    case (state_q)
      ST_OFF: begin
        if (run_q) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (!run_q) begin
          state_d = (cfg_q.soff_dly == 16'h0000) ? ST_OFF : ST_OFF_DLY;
        end
      end
      ST_OFF_DLY: begin
        if (run_q) begin
          state_d = ST_ON;
        end else if (phase_q >= cfg_q.soff_dly) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
    // Each delay restarts when its phase is re-entered
    phase_d = (state_d != state_q) ? 16'h0000 : ms_step(phase_q, tick_q);
    comm_d  = (host_cmd || state_q != ST_ON) ? 16'h0000 : ms_step(comm_q, tick_q);
    servo_d = (state_d != ST_OFF);
    case (cfg_q.brk_mode)
      BRK_MODE_RELEASE: brake_d = 1'b1;
      BRK_MODE_HOLD:    brake_d = 1'b0;
      default:          brake_d = rel_ok;
    endcase
    db_d = power_off ||
           (cfg_q.db_cond >= DB_ON_ALARM && alarm_q != ALM_NONE) ||
           (cfg_q.db_cond == DB_ON_SERVO_OFF && !servo_q);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q   <= CFG_RST;
      state_q <= ST_OFF;
      run_q   <= 1'b0;
      tmo_q   <= 1'b0;
      pre_q   <= 16'h0000;
      tick_q  <= 1'b0;
      phase_q <= 16'h0000;
      comm_q  <= 16'h0000;
      servo_q <= 1'b0;
      brake_q <= 1'b0;
      db_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      state_q <= state_d;
      run_q   <= run_d;
      tmo_q   <= tmo_d;
      pre_q   <= pre_d;
      tick_q  <= tick_d;
      phase_q <= phase_d;
      comm_q  <= comm_d;
      servo_q <= servo_d;
      brake_q <= brake_d;
      db_q    <= db_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Monitor group: one cycle of sampling, alarms one cycle later
  always_comb begin
    cmd_olf_d = olf_calc(sense.cmd_cur, thr.ol_cur);
    act_olf_d = olf_calc(sense.act_cur, thr.ol_cur);
    temp_d    = sense.temp;
    volt_d    = sense.volt;
    step_d    = 16'h0000;
    if (prog.active) begin
      step_d[7:0] = prog.step;
    end
    step_d[STEP_END_BIT] = prog.done;
    stop_d = (spd_abs <= cfg_q.stop_spd);
    // Overloads outrank thermal and supply alarms
    if (cmd_olf_q >= OLF_LIMIT) begin
      alarm_d = ALM_CMD_OL;
    end else if (act_olf_q >= OLF_LIMIT) begin
      alarm_d = ALM_ACT_OL;
    end else if (temp_q >= thr.ovheat) begin
      alarm_d = ALM_OVHEAT;
    end else if (volt_q >= thr.ovvolt) begin
      alarm_d = ALM_OVERVOLT;
    end else if (volt_q < thr.uvvolt) begin
      alarm_d = ALM_UNDERVOLT;
    end else begin
      alarm_d = ALM_NONE;
    end
    pg_d = inertia_est ? cfg_q.p_gain : norm_p_gain;
    ig_d = inertia_est ? cfg_q.i_gain : norm_i_gain;
    m1_d = mon_scale(sense.cmd_cur, cfg_q.mon1_gain);
    m2_d = mon_scale(sense.speed, cfg_q.mon2_gain);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_olf_q <= 16'h0000;
      act_olf_q <= 16'h0000;
      temp_q    <= 16'h0000;
      volt_q    <= 16'h0000;
      step_q    <= 16'h0000;
      stop_q    <= 1'b0;
      alarm_q   <= ALM_NONE;
      pg_q      <= 16'h0000;
      ig_q      <= 16'h0000;
      m1_q      <= 16'sh0000;
      m2_q      <= 16'sh0000;
    end else begin
      cmd_olf_q <= cmd_olf_d;
      act_olf_q <= act_olf_d;
      temp_q    <= temp_d;
      volt_q    <= volt_d;
      step_q    <= step_d;
      stop_q    <= stop_d;
      alarm_q   <= alarm_d;
      pg_q      <= pg_d;
      ig_q      <= ig_d;
      m1_q      <= m1_d;
      m2_q      <= m2_d;
    end
  end

  assign servo_on     = servo_q;
  assign brake_out    = brake_q;
  assign dyn_brake    = db_q;
  assign alarm_code   = alarm_q;
  assign speed_p_gain = pg_q;
  assign speed_i_gain = ig_q;
  assign mon1_out     = m1_q;
  assign mon2_out     = m2_q;

  a_brake_wait_dly: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg_q.brk_mode == BRK_MODE_FOLLOW && state_q == ST_ON && phase_q < cfg_q.brk_dly)
    |=> !brake_q)
    else $error("Brake released before its delay");

  a_comm_loss_off: assert property (@(posedge core_clk) disable iff (!resetn)
    (timeout && !wr_en) |=> !run_q ##0 tmo_q)
    else $error("Timeout did not drop the servo request");

  a_tmo_zero_keep: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg_q.comm_tmo == 16'h0000 && run_q && !wr_en) |=> run_q)
    else $error("Servo dropped with timeout disabled");

  a_brake_forced_rel: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg_q.brk_mode == BRK_MODE_RELEASE) |=> brake_q)
    else $error("Forced release not honoured");

  a_brake_forced_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg_q.brk_mode == BRK_MODE_HOLD) |=> !brake_q)
    else $error("Forced brake not honoured");

  a_brake_servo_off: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg_q.brk_mode == BRK_MODE_FOLLOW && state_q != ST_ON) |=> !brake_q)
    else $error("Brake released while servo off");

  a_db_cond_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    (cfg_q.db_cond == 8'h00) |=> (db_q == $past(power_off)))
    else $error("Dynamic brake not following power shutoff");

  a_cmd_ol_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
    (cmd_olf_q >= OLF_LIMIT) |=> (alarm_q == ALM_CMD_OL))
    else $error("Command overload alarm missing");

  a_undervolt_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
    (cmd_olf_q < OLF_LIMIT && act_olf_q < OLF_LIMIT && temp_q < thr.ovheat &&
     volt_q < thr.ovvolt && volt_q < thr.uvvolt && $stable(thr)) |=>
    (alarm_q == ALM_UNDERVOLT))
    else $error("Undervoltage alarm missing");

  a_step_end_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    prog.done |=> step_q[STEP_END_BIT])
    else $error("Program end flag missing");

  a_soff_delay_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == ST_OFF_DLY && !run_q && phase_q < cfg_q.soff_dly) |=> servo_q)
    else $error("Servo left on delay too early");

  a_overheat_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
    (cmd_olf_q < OLF_LIMIT && act_olf_q < OLF_LIMIT && temp_q >= thr.ovheat) |=>
    (alarm_q == ALM_OVHEAT))
    else $error("Overheat alarm missing");

  a_overvolt_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
    (cmd_olf_q < OLF_LIMIT && act_olf_q < OLF_LIMIT && temp_q < thr.ovheat &&
     volt_q >= thr.ovvolt) |=> (alarm_q == ALM_OVERVOLT))
    else $error("Overvoltage alarm missing");

  a_est_gain_sel: assert property (@(posedge core_clk) disable iff (!resetn)
    inertia_est |=> (speed_p_gain == $past(cfg_q.p_gain) &&
                     speed_i_gain == $past(cfg_q.i_gain)))
    else $error("Estimation gains not applied");

  a_ms_tick_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
    (pre_q == PRE_LAST) |=> (tick_q && pre_q == 16'h0000))
    else $error("Millisecond tick not issued on wrap");

endmodule

// ==== hw/sbps_pkg.sv ====
// Summary of operation
// - Brake release delayed after servo-on, in ms
// - Servo-off when host commands stop arriving
// - Timeout of zero disables automatic servo-off
// - Brake mode one forces brake output high
// - Brake mode 99 forces brake output low
// - Brake mode zero follows servo state
// - Dynamic brake condition selector 0, 1, 2
// - Command overload factor, alarm 22 at 1000
// - Actual overload factor, alarm 21 at 1000
// - Temperature at threshold raises alarm 51
// - Voltage at threshold raises alarm 71
// - Voltage below threshold raises alarm 72
// - Program step in bits 7:0, end bit 12
// - Stop-speed flag at status bit 14
// - Monitor 1 signed gain, multiply or divide
// - Monitor 2 independent gain, same encoding
// - Inertia estimation uses dedicated speed gains
// - Servo-off command delayed by programmed ms
package sbps_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned MS_CYC       = CLK_HZ / 1000 * TICK_MS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_P_GAIN    = 8'h04;
  localparam logic [7:0] OFS_I_GAIN    = 8'h08;
  localparam logic [7:0] OFS_BRK_DLY   = 8'h0c;
  localparam logic [7:0] OFS_COMM_TMO  = 8'h10;
  localparam logic [7:0] OFS_BRK_MODE  = 8'h14;
  localparam logic [7:0] OFS_DB_COND   = 8'h18;
  localparam logic [7:0] OFS_SOFF_DLY  = 8'h1c;
  localparam logic [7:0] OFS_STOP_SPD  = 8'h20;
  localparam logic [7:0] OFS_MON1_GAIN = 8'h24;
  localparam logic [7:0] OFS_MON2_GAIN = 8'h28;
  localparam logic [7:0] OFS_CMD_OLF   = 8'h40;
  localparam logic [7:0] OFS_ACT_OLF   = 8'h44;
  localparam logic [7:0] OFS_TEMP      = 8'h48;
  localparam logic [7:0] OFS_VOLT      = 8'h4c;
  localparam logic [7:0] OFS_STEP_STAT = 8'h50;
  localparam logic [7:0] OFS_STATUS    = 8'h54;
  localparam logic [7:0] OFS_ALARM     = 8'h58;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned ST_SERVO_BIT  = 0;
  localparam int unsigned ST_BRAKE_BIT  = 1;
  localparam int unsigned ST_DB_BIT     = 2;
  localparam int unsigned ST_TMO_BIT    = 3;
  localparam int unsigned ST_STOP_BIT   = 14;
  localparam int unsigned STEP_END_BIT  = 12;

  // Encodings
  localparam logic [15:0] BRK_MODE_FOLLOW  = 16'h0000;
  localparam logic [15:0] BRK_MODE_RELEASE = 16'h0001;
  localparam logic [15:0] BRK_MODE_HOLD    = 16'h0063;
  localparam logic [7:0]  DB_ON_ALARM      = 8'h01;
  localparam logic [7:0]  DB_ON_SERVO_OFF  = 8'h02;
  localparam logic [15:0] OLF_LIMIT        = 16'h03e8;
  localparam logic [31:0] OLF_SCALE        = 32'h0000_03e8;
  localparam logic [7:0]  ALM_NONE         = 8'h00;
  localparam logic [7:0]  ALM_ACT_OL       = 8'h15;
  localparam logic [7:0]  ALM_CMD_OL       = 8'h16;
  localparam logic [7:0]  ALM_OVHEAT       = 8'h33;
  localparam logic [7:0]  ALM_OVERVOLT     = 8'h47;
  localparam logic [7:0]  ALM_UNDERVOLT    = 8'h48;

  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_OFF_DLY} sbps_state_t;

  typedef struct packed {
    logic [15:0] p_gain;
    logic [15:0] i_gain;
    logic [15:0] brk_dly;
    logic [15:0] comm_tmo;
    logic [15:0] brk_mode;
    logic [7:0]  db_cond;
    logic [15:0] soff_dly;
    logic [15:0] stop_spd;
    logic [15:0] mon1_gain;
    logic [15:0] mon2_gain;
  } sbps_cfg_t;

  localparam sbps_cfg_t CFG_RST = '{
    p_gain:    16'h00c8,
    i_gain:    16'h007d,
    brk_dly:   16'h0000,
    comm_tmo:  16'h03e8,
    brk_mode:  16'h0000,
    db_cond:   8'h00,
    soff_dly:  16'h0000,
    stop_spd:  16'h000a,
    mon1_gain: 16'h0001,
    mon2_gain: 16'h0001
  };

  typedef struct packed {
    logic [15:0]        cmd_cur;
    logic [15:0]        act_cur;
    logic [15:0]        temp;
    logic [15:0]        volt;
    logic signed [15:0] speed;
  } sbps_sense_t;

  typedef struct packed {
    logic [15:0] ol_cur;
    logic [15:0] ovheat;
    logic [15:0] ovvolt;
    logic [15:0] uvvolt;
  } sbps_thr_t;

  typedef struct packed {
    logic       active;
    logic       done;
    logic [7:0] step;
  } sbps_prog_t;

endpackage

// ==== test/sbps_host_model.sv ====
`timescale 1ns/1ns
module sbps_host_model #(
  parameter int unsigned PERIOD = 20
) (
  input  wire logic core_clk, // System clock
  input  wire logic resetn,   // Reset, active low
  input  wire logic cmd_en,   // Host keeps sending commands
  output logic      host_cmd  // One-cycle command pulse
);
  int unsigned cnt_q;

  // A silent host sends nothing at all, which is what the watchdog must catch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q    <= 0;
      host_cmd <= 1'b0;
    end else begin
      cnt_q    <= (cnt_q + 1 >= PERIOD) ? 0 : cnt_q + 1;
      host_cmd <= cmd_en && (cnt_q == 0);
    end
  end
endmodule

// ==== test/tb_sbps_top.sv ====
`timescale 1ns/1ns
module tb_sbps_top import sbps_pkg::*;;
  logic               core_clk;
  logic               resetn;
  logic [7:0]         paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               host_cmd;
  logic               cmd_en;
  logic               power_off;
  logic               inertia_est;
  logic [15:0]        norm_p_gain;
  logic [15:0]        norm_i_gain;
  sbps_sense_t        sense;
  sbps_thr_t          thr;
  sbps_prog_t         prog;
  logic               servo_on;
  logic               brake_out;
  logic               dyn_brake;
  logic [7:0]         alarm_code;
  logic [15:0]        speed_p_gain;
  logic [15:0]        speed_i_gain;
  logic signed [15:0] mon1_out;
  logic signed [15:0] mon2_out;
  int                 err_total = 0;
  int                 samples_checked = 0;
  logic [31:0]        rd;
  logic               rerr;
  logic [7:0]         ro [10] = '{OFS_P_GAIN, OFS_I_GAIN, OFS_BRK_DLY, OFS_COMM_TMO,
                                  OFS_BRK_MODE, OFS_DB_COND, OFS_MON1_GAIN, OFS_MON2_GAIN,
                                  OFS_SOFF_DLY, OFS_STOP_SPD};
  logic [15:0]        rv [10] = '{16'h00c8, 16'h007d, 16'h0000, 16'h03e8,
                                  16'h0000, 16'h0000, 16'h0001, 16'h0001,
                                  16'h0000, 16'h000a};
  // Each row: command current, actual current, temperature, voltage, alarm
  logic [15:0]        av [8][5] = '{
    '{16'h03e7, 16'h0000, 16'h00fa, 16'h0af0, 16'h0000},
    '{16'h03e8, 16'h0000, 16'h00fa, 16'h0af0, 16'h0016},
    '{16'h0000, 16'h03e8, 16'h00fa, 16'h0af0, 16'h0015},
    '{16'h0000, 16'h0000, 16'h0351, 16'h0af0, 16'h0000},
    '{16'h0000, 16'h0000, 16'h0352, 16'h0af0, 16'h0033},
    '{16'h0000, 16'h0000, 16'h00fa, 16'h1004, 16'h0047},
    '{16'h0000, 16'h0000, 16'h00fa, 16'h03e8, 16'h0000},
    '{16'h0000, 16'h0000, 16'h00fa, 16'h03e7, 16'h0048}};
  logic signed [15:0] gl [4] = '{16'sh000a, -16'sh0004, 16'sh0000, -16'sh0001};

  // Short millisecond so the long delays stay cheap to simulate
  sbps_top #(.MS_CYCLES(10)) sbps_top_inst (
    .core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .host_cmd, .power_off, .inertia_est, .norm_p_gain, .norm_i_gain, .sense,
    .thr, .prog, .servo_on, .brake_out, .dyn_brake, .alarm_code, .speed_p_gain,
    .speed_i_gain, .mon1_out, .mon2_out);
  sbps_host_model #(.PERIOD(20)) sbps_host_model_inst (.core_clk, .resetn, .cmd_en, .host_cmd);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // An idle edge first, so psel is never driven twice in one time step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(what, rd, e);
  endtask

  task automatic wait_out(input logic v, input bit brk, input int lim);
    int k;
    k = 0;
    while ((brk ? brake_out : servo_on) !== v && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if ((brk ? brake_out : servo_on) !== v) begin
      err_total++;
      test_done();
    end
  endtask

  function automatic logic [15:0] scl(input int v, input int g);
    return (g > 0) ? 16'(v * g) : (g < -1) ? 16'(v / -g) : 16'(v);
  endfunction

  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sense = '{16'h0000, 16'h0000, 16'h00fa, 16'h0af0, 16'sh0000};
    thr = '{16'h03e8, 16'h0352, 16'h1004, 16'h03e8};
    prog = '0;
    cmd_en = 1'b1;
    power_off = 1'b0;
    inertia_est = 1'b0;
    norm_p_gain = 16'h0064;
    norm_i_gain = 16'h0032;
    cyc(8);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdc("reset value", ro[i], {16'h0000, rv[i]});
    apb(8'h3c, 1'b0, 32'h0000_0000);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped error", rerr, 32'h0000_0001);
    wr(OFS_TEMP, 32'h0000_1234);
    rdc("read-only temp", OFS_TEMP, 32'h0000_00fa);
    wr(OFS_BRK_DLY, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_out(1'b1, 0, 8);
    cyc(15);
    chk("brake early", brake_out, 32'h0000_0000);
    wait_out(1'b1, 1, 30);
    chk("brake released", brake_out, 32'h0000_0001);
    wr(OFS_BRK_MODE, 32'h0000_0063);
    cyc(3);
    chk("forced hold", brake_out, 32'h0000_0000);
    wr(OFS_BRK_MODE, 32'h0000_0000);
    wr(OFS_SOFF_DLY, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0000);
    cyc(15);
    chk("off delay", servo_on, 32'h0000_0001);
    wait_out(1'b0, 0, 30);
    cyc(3);
    chk("brake applied", brake_out, 32'h0000_0000);
    wr(OFS_BRK_MODE, 32'h0000_0001);
    cyc(3);
    chk("forced release", brake_out, 32'h0000_0001);
    wr(OFS_BRK_MODE, 32'h0000_0000);
    wr(OFS_SOFF_DLY, 32'h0000_0000);
    wr(OFS_COMM_TMO, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_out(1'b1, 0, 8);
    cyc(150);
    chk("host alive", servo_on, 32'h0000_0001);
    cmd_en <= 1'b0;
    cyc(10);
    chk("timeout early", servo_on, 32'h0000_0001);
    wait_out(1'b0, 0, 90);
    apb(OFS_STATUS, 1'b0, 32'h0000_0000);
    chk("timeout flag", rd[ST_TMO_BIT], 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0008);
    apb(OFS_STATUS, 1'b0, 32'h0000_0000);
    chk("timeout flag clear", rd[ST_TMO_BIT], 32'h0000_0000);
    wr(OFS_COMM_TMO, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_out(1'b1, 0, 8);
    cyc(150);
    chk("timeout off", servo_on, 32'h0000_0001);
    for (int c = 0; c < 3; c++) begin
      wr(OFS_DB_COND, 32'(c));
      power_off <= 1'b1;
      cyc(4);
      chk("dyn power", dyn_brake, 32'h0000_0001);
      power_off <= 1'b0;
      sense.temp <= 16'h0352;
      cyc(4);
      chk("dyn alarm", dyn_brake, 32'(c >= 1));
      sense.temp <= 16'h00fa;
      wr(OFS_CTRL, 32'h0000_0000);
      wait_out(1'b0, 0, 8);
      cyc(3);
      chk("dyn servo off", dyn_brake, 32'(c == 2));
      wr(OFS_CTRL, 32'h0000_0001);
      wait_out(1'b1, 0, 8);
    end
    for (int i = 0; i < 8; i++) begin
      sense.cmd_cur <= av[i][0];
      sense.act_cur <= av[i][1];
      sense.temp <= av[i][2];
      sense.volt <= av[i][3];
      cyc(4);
      chk("alarm", alarm_code, {16'h0000, av[i][4]});
      rdc("cmd factor", OFS_CMD_OLF, {16'h0000, av[i][0]});
      rdc("act factor", OFS_ACT_OLF, {16'h0000, av[i][1]});
      rdc("voltage", OFS_VOLT, {16'h0000, av[i][3]});
    end
    prog <= '{1'b1, 1'b0, 8'h2a};
    cyc(4);
    rdc("step", OFS_STEP_STAT, 32'h0000_002a);
    prog <= '{1'b1, 1'b1, 8'h2a};
    cyc(4);
    rdc("step end", OFS_STEP_STAT, 32'h0000_102a);
    sense.speed <= -16'sh000a;
    cyc(4);
    apb(OFS_STATUS, 1'b0, 32'h0000_0000);
    chk("stop flag set", rd[ST_STOP_BIT], 32'h0000_0001);
    sense.speed <= 16'sh000b;
    cyc(4);
    apb(OFS_STATUS, 1'b0, 32'h0000_0000);
    chk("stop flag clear", rd[ST_STOP_BIT], 32'h0000_0000);
    sense.cmd_cur <= 16'h0064;
    sense.speed <= 16'sh00c8;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MON1_GAIN, {16'h0000, gl[i]});
      wr(OFS_MON2_GAIN, {16'h0000, gl[i]});
      cyc(4);
      chk("monitor 1", {16'h0000, mon1_out}, {16'h0000, scl(100, gl[i])});
      chk("monitor 2", {16'h0000, mon2_out}, {16'h0000, scl(200, gl[i])});
    end
    chk("normal p gain", speed_p_gain, 32'h0000_0064);
    chk("normal i gain", speed_i_gain, 32'h0000_0032);
    wr(OFS_P_GAIN, 32'h0000_01f4);
    inertia_est <= 1'b1;
    cyc(4);
    chk("estimation p gain", speed_p_gain, 32'h0000_01f4);
    chk("estimation i gain", speed_i_gain, 32'h0000_007d);
    test_done();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    test_done();
  end
endmodule
